// ==== bench/nmhl_core_tb.sv ====
// Purpose: self-checking bench of the module host link
// Assumes: wake counts shortened to 20, 30, 10 and 15 cycles
// Notes:   hibernate low time is shortened with the counts
`timescale 1ns/1ps
`default_nettype none
module nmhl_core_tb
   import nmhl_pkg::*;
;
   logic        ref_clk, nrst, sleep_request_n, link_sel, baud_load;
   logic        temp_drift_big, rtc_stop_in_hib, attn_req, tx_valid;
   logic        rx_ready;
   logic [15:0] baud_div_in;
   logic [31:0] tx_word;
   wire         spi_clk, host_select_n, spi_mosi, spi_miso, spi_miso_oe;
   wire         module_attention_line, uart_rxd, uart_txd, uart_cts_n;
   wire         uart_rts_n, tx_ready, rx_valid, link_ready, hibernating;
   wire         rtc_osc_en;
   wire  [31:0] rx_word;
   int          n_fail = 0;
   int          n_checks = 0;
   int          n;
   logic [7:0]  b;

   nmhl_core #(.P_HW_WAKE_CYC(20), .P_INIT_CYC(30), .P_HIB_WAKE_CYC(10),
      .P_RECAL_CYC(15)) DUT (.ref_clk, .nrst, .spi_clk, .host_select_n,
      .spi_mosi, .spi_miso, .spi_miso_oe, .module_attention_line,
      .sleep_request_n, .uart_rxd, .uart_txd, .uart_cts_n, .uart_rts_n,
      .link_sel, .baud_load, .baud_div_in, .temp_drift_big,
      .rtc_stop_in_hib, .attn_req, .tx_word, .tx_valid, .tx_ready,
      .rx_word, .rx_valid, .rx_ready, .link_ready, .hibernating,
      .rtc_osc_en);

   nmhl_host_model host (.spi_clk, .host_select_n, .spi_mosi, .uart_rxd,
      .uart_cts_n, .spi_miso, .uart_txd, .uart_rts_n);

   always #2.5 ref_clk = ~ref_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   task automatic cyc(input int k);
      repeat (k) @(negedge ref_clk);
   endtask : cyc

   // hibernate round trip; wake bound checked from both sides
   task automatic hib(input logic drift, input int wake);
      sleep_request_n = 1'b0;
      temp_drift_big = drift;
      rtc_stop_in_hib = drift;
      cyc(3);
      chk(hibernating, 1'b1);
      chk(link_ready, 1'b0);
      chk(rtc_osc_en, !drift);
      chk(uart_txd, 1'b1);
      cyc(20); // low width kept, scaled with the counts
      sleep_request_n = 1'b1;
      cyc(wake - 2);
      chk(link_ready, 1'b0);
      cyc(4);
      chk(link_ready, 1'b1);
   endtask : hib

   // main sequence, all inputs change on the falling edge
   initial begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      sleep_request_n = 1'b1;
      link_sel = 1'b1;
      baud_load = 1'b0;
      baud_div_in = 16'h0010;
      temp_drift_big = 1'b0;
      rtc_stop_in_hib = 1'b0;
      attn_req = 1'b0;
      tx_valid = 1'b0;
      tx_word = 32'h44332211;
      rx_ready = 1'b0;
      cyc(2);
      nrst = 1'b1;
      chk(uart_rts_n, 1'b1);
      cyc(48);
      chk(link_ready, 1'b0);
      cyc(4);
      chk(link_ready, 1'b1);
      tx_valid = 1'b1;
      chk(tx_ready, 1'b1);
      cyc(1);
      tx_valid = 1'b0;
      @(negedge uart_txd);
      chk(module_attention_line, 1'b1);
      n = 0;
      while (uart_txd !== 1'b1 && n < 5000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(n, DIV_START);
      cyc(1);
      hib(1'b0, 13);
      hib(1'b1, 28);
      chk(module_attention_line, 1'b0);
      // too small a divisor lands on the fastest legal rate
      host.set_cts(1'b1); // synced high before the word arrives
      baud_load = 1'b1;
      cyc(1);
      baud_load = 1'b0;
      tx_valid = 1'b1;
      cyc(1);
      tx_valid = 1'b0;
      cyc(200);
      chk(uart_txd, 1'b1);
      host.set_cts(1'b0);
      for (int i = 0; i < 4; i++) begin
         host.uart_recv(DIV_MIN, b);
         chk(b, 8'h11 * (i + 1));
      end
      for (int i = 0; i < 4; i++)
         host.uart_send(8'hA1 + 8'h11 * i, DIV_MIN);
      cyc(8);
      chk(rx_valid, 1'b1);
      chk(rx_word, 32'hD4C3B2A1);
      chk(uart_rts_n, 1'b1);
      rx_ready = 1'b1;
      cyc(1);
      rx_ready = 1'b0;
      link_sel = 1'b0;
      // queued word leaves one byte late; first frame reads idle fill
      tx_valid = 1'b1;
      cyc(1);
      tx_valid = 1'b0;
      cyc(4);
      for (int i = 0; i < 4; i++) begin
         host.spi_xfer(8'h5A + 8'h11 * i, b);
         chk(b, (i == 0) ? 8'h00 : 8'(8'h11 * i));
      end
      cyc(8);
      chk(rx_word, 32'h8D7C6B5A);
      attn_req = 1'b1;
      cyc(3);
      chk(module_attention_line, 1'b1);
      attn_req = 1'b0;
      cyc(3);
      chk(module_attention_line, 1'b0);
      wrap_up();
   end

   // whole run needs about 8k cycles; 20k leaves ample margin
   initial begin
      #100000;
      n_fail++;
      wrap_up();
   end
endmodule : nmhl_core_tb
`default_nettype wire

// ==== bench/nmhl_host_model.sv ====
// Purpose: host side of the link: SPI master and UART peer
// Assumes: core period of 5 ns for UART bit times
// Notes:   link clock runs only inside a frame, idle low between
`timescale 1ns/1ps
`default_nettype none
module nmhl_host_model (
   output logic      spi_clk,
   output logic      host_select_n,
   output logic      spi_mosi,
   output logic      uart_rxd,
   output logic      uart_cts_n,
   input  wire logic spi_miso,
   input  wire logic uart_txd,
   input  wire logic uart_rts_n
);
   // host owns clock, select and data toward the module
   initial begin
      spi_clk = 1'b0;
      host_select_n = 1'b1;
      spi_mosi = 1'b0;
      uart_rxd = 1'b1;
      uart_cts_n = 1'b0;
   end

   // one byte, 8 MHz link clock keeps well under the ceiling
   task automatic spi_xfer(input logic [7:0] tb, output logic [7:0] rb);
      host_select_n = 1'b0; // select leads first edge
      #20;
      for (int i = 7; i >= 0; i--) begin
         spi_mosi = tb[i];
         #62.5 spi_clk = 1'b1; // sample on the rise
         rb[i] = spi_miso;
         #62.5 spi_clk = 1'b0;
      end
      #20 host_select_n = 1'b1; // release trails last edge
      spi_mosi = ~spi_mosi; // released line must not look stable
      #20; // select stays high between frames
   endtask : spi_xfer

   // flow control toward the module, one driver for the line
   task automatic set_cts(input logic v);
      uart_cts_n = v;
   endtask : set_cts

   // 8N1, LSB first, only while the module signals room
   task automatic uart_send(input logic [7:0] b, input int div);
      wait (uart_rts_n === 1'b0);
      uart_rxd = 1'b0;
      #(div * 5);
      for (int i = 0; i < 8; i++) begin
         uart_rxd = b[i];
         #(div * 5);
      end
      uart_rxd = 1'b1;
      #(div * 5);
   endtask : uart_send

   // always awake, takes every byte offered
   task automatic uart_recv(input int div, output logic [7:0] b);
      @(negedge uart_txd);
      #(div * 5 / 2);
      for (int i = 0; i < 8; i++) begin
         #(div * 5);
         b[i] = uart_txd; // LSB first
      end
      #(div * 5);
   endtask : uart_recv
endmodule : nmhl_host_model
`default_nettype wire

// ==== core/nmhl_core.sv ====
// Purpose: host link of the network module: power sequence, UART, SPI
// Assumes: firmware side on ref_clk; pins synchronised here
// Notes:   32-bit words are moved as four bytes, least significant first
`timescale 1ns/1ps
`default_nettype none
module nmhl_core
   import nmhl_pkg::*;
#(
   parameter int P_HW_WAKE_CYC  = HW_WAKE_CYC,
   parameter int P_INIT_CYC     = INIT_CYC,
   parameter int P_HIB_WAKE_CYC = HIB_WAKE_CYC,
   parameter int P_RECAL_CYC    = RECAL_CYC
)(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        spi_clk,
   input  wire logic        host_select_n,
   input  wire logic        spi_mosi,
   output logic             spi_miso,
   output logic             spi_miso_oe,
   output logic             module_attention_line,
   input  wire logic        sleep_request_n,
   input  wire logic        uart_rxd,
   output logic             uart_txd,
   input  wire logic        uart_cts_n,
   output logic             uart_rts_n,
   input  wire logic        link_sel,
   input  wire logic        baud_load,
   input  wire logic [15:0] baud_div_in,
   input  wire logic        temp_drift_big,
   input  wire logic        rtc_stop_in_hib,
   input  wire logic        attn_req,
   input  wire logic [31:0] tx_word,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [31:0]      rx_word,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic             link_ready,
   output logic             hibernating,
   output logic             rtc_osc_en
);
   typedef struct packed {
      nmhl_pwr_t        pwr;
      logic [CNT_W-1:0] pcnt;
      logic             recal;
      logic             link_rst;
      logic [1:0]       hib_s;
      logic [1:0]       rxd_s;
      logic [1:0]       cts_s;
      logic [2:0]       rtg_s;
      logic [1:0]       ack_s;
      logic [15:0]      div;
      nmhl_uart_t       txs;
      logic [15:0]      txc;
      logic [2:0]       txb;
      logic [7:0]       txsh;
      logic             txd;
      nmhl_uart_t       rxs;
      logic [15:0]      rxc;
      logic [2:0]       rxb;
      logic [7:0]       rxsh;
      logic [31:0]      txw;
      logic [1:0]       txi;
      logic             txw_full;
      logic [7:0]       spi_tx;
      logic             spi_tgl;
      logic [23:0]      rxw;
      logic [1:0]       rxi;
      logic [31:0]      rx_out;
      logic             rx_valid;
      logic             attn;
   } nmhl_core_st_t;

   nmhl_core_st_t s, n;
   logic          ready;
   logic          give_byte;
   logic          got_byte;
   logic [7:0]    cur_byte;
   logic [7:0]    in_byte;

   nmhl_spi_if spi_bus ();

   // link-clock side of the SPI port
   nmhl_spi_link u_spi (
      .spi_clk       (spi_clk),
      .host_select_n (host_select_n),
      .spi_mosi      (spi_mosi),
      .spi_miso      (spi_miso),
      .spi_miso_oe   (spi_miso_oe),
      .lnk           (spi_bus.link)
   );

   // last cycle of a wake phase
   function automatic logic hit(input logic [CNT_W-1:0] c, input int cyc);
      return c == CNT_W'(cyc - 1);
   endfunction : hit

   // byte i of a little-endian word
   function automatic logic [7:0] byte_at(input logic [31:0] w,
                                         input logic [1:0] i);
      return w[8*i +: 8];
   endfunction : byte_at

   assign ready    = (s.pwr == ST_READY);
   assign cur_byte = byte_at(s.txw, s.txi);

   // whole next state; power sequence first, link traffic after
   always_comb begin
      n         = s;
      give_byte = 1'b0;
      got_byte  = 1'b0;
      in_byte   = s.rxsh;
      n.hib_s   = {s.hib_s[0], sleep_request_n};
      n.rxd_s   = {s.rxd_s[0], uart_rxd};
      n.cts_s   = {s.cts_s[0], uart_cts_n};
      n.rtg_s   = {s.rtg_s[1:0], spi_bus.rx_tgl};
      n.ack_s   = {s.ack_s[0], spi_bus.tx_ack};
      n.pcnt    = CNT_W'(s.pcnt + 1'b1);
      n.link_rst = 1'b0;

      // wake-up timing after reset and after hibernate
      case (s.pwr)
         ST_HW: begin
            if (hit(s.pcnt, P_HW_WAKE_CYC)) begin
               n.pwr  = ST_INIT;
               n.pcnt = '0;
            end
         end
         ST_INIT: begin
            if (hit(s.pcnt, P_INIT_CYC)) begin
               n.pwr  = ST_READY;
               n.pcnt = '0;
            end
         end
         ST_READY: n.pcnt = '0;
         ST_HIB: begin
            n.pcnt = '0;
            if (s.hib_s[1]) begin
               n.pwr   = ST_HWAKE;
               n.recal = temp_drift_big;
            end
         end
         ST_HWAKE: begin
            // drift adds the recalibration time on top of the wake time
            if (hit(s.pcnt, s.recal ? P_HIB_WAKE_CYC + P_RECAL_CYC
                                    : P_HIB_WAKE_CYC)) begin
               n.pwr  = ST_READY;
               n.pcnt = '0;
            end
         end
         default: begin
            n.pwr  = ST_HW;
            n.pcnt = '0;
         end
      endcase
      // request low wins from any state; logic is power-gated there
      if (!s.hib_s[1]) begin
         n.pwr  = ST_HIB;
         n.pcnt = '0;
      end

      // firmware word intake
      if (tx_valid && ready && !s.txw_full) begin
         n.txw      = tx_word;
         n.txw_full = 1'b1;
         n.txi      = '0;
      end

      // hand out the next byte, low byte first, to the chosen port
      if (link_sel == LINK_UART) begin
         give_byte = ready && s.txw_full && s.txs == UT_IDLE
                     && !s.cts_s[1];
      end else begin
         give_byte = ready && s.txw_full && s.ack_s[1] == s.spi_tgl;
      end
      if (give_byte) begin
         n.txi = s.txi + 2'h1;
         if (s.txi == BYTE_LAST) n.txw_full = 1'b0;
         if (link_sel == LINK_UART) begin
            n.txs  = UT_START;
            n.txsh = cur_byte;
            n.txd  = 1'b0;
            n.txc  = s.div - 16'h1;
         end else begin
            n.spi_tx  = cur_byte;
            n.spi_tgl = ~s.spi_tgl;
         end
      end

      // 8N1 transmitter, LSB first
      if (s.txs != UT_IDLE && s.txc != 16'h0) begin
         n.txc = s.txc - 16'h1;
      end else begin
         case (s.txs)
            UT_IDLE: ;
            UT_START: begin
               n.txs = UT_DATA;
               n.txb = '0;
               n.txd = s.txsh[0];
               n.txc = s.div - 16'h1;
            end
            UT_DATA: begin
               n.txc = s.div - 16'h1;
               if (s.txb == BIT_LAST) begin
                  n.txs = UT_STOP;
                  n.txd = 1'b1;
               end else begin
                  n.txb  = s.txb + 3'h1;
                  n.txsh = {1'b0, s.txsh[7:1]};
                  n.txd  = s.txsh[1];
               end
            end
            UT_STOP: n.txs = UT_IDLE;
            default: begin
               n.txs = UT_IDLE;
               n.txd = 1'b1;
            end
         endcase
      end

      // 8N1 receiver sampling mid-bit; a bad stop bit drops the byte
      if (s.rxs != UT_IDLE && s.rxc != 16'h0) begin
         n.rxc = s.rxc - 16'h1;
      end else begin
         case (s.rxs)
            UT_IDLE: begin
               if (!s.rxd_s[1] && link_sel == LINK_UART) begin
                  n.rxs = UT_START;
                  n.rxc = {1'b0, s.div[15:1]};
               end
            end
            UT_START: begin
               n.rxs = s.rxd_s[1] ? UT_IDLE : UT_DATA;
               n.rxb = '0;
               n.rxc = s.div - 16'h1;
            end
            UT_DATA: begin
               n.rxsh = {s.rxd_s[1], s.rxsh[7:1]};
               n.rxc  = s.div - 16'h1;
               n.rxb  = s.rxb + 3'h1;
               if (s.rxb == BIT_LAST) n.rxs = UT_STOP;
            end
            UT_STOP: begin
               n.rxs    = UT_IDLE;
               got_byte = s.rxd_s[1];
            end
            default: n.rxs = UT_IDLE;
         endcase
      end
      // a byte finished by the SPI engine
      if (link_sel == LINK_SPI && (s.rtg_s[2] ^ s.rtg_s[1])) begin
         got_byte = 1'b1;
         in_byte  = spi_bus.rx_byte;
      end

      // pack bytes into a fixed 32-bit little-endian word
      if (rx_ready) n.rx_valid = 1'b0;
      if (got_byte && ready) begin
         n.rxi = s.rxi + 2'h1;
         if (s.rxi == BYTE_LAST) begin
            n.rx_out   = {in_byte, s.rxw};
            n.rx_valid = 1'b1;
         end else begin
            n.rxw[8*s.rxi +: 8] = in_byte;
         end
      end

      // baud change only between characters, never below the floor
      if (baud_load && ready && s.txs == UT_IDLE && s.rxs == UT_IDLE) begin
         n.div = (baud_div_in < DIV_MIN) ? DIV_MIN : baud_div_in;
      end

      // attention asks the host to clock out pending data
      n.attn = ready && (attn_req || s.txw_full);

      // hibernate loses link state and restarts at the start rate
      if (s.pwr == ST_HIB) begin
         n.div      = DIV_START;
         n.txs      = UT_IDLE;
         n.rxs      = UT_IDLE;
         n.txd      = 1'b1;
         n.txw_full = 1'b0;
         n.rxi      = '0;
         n.rx_valid = 1'b0;
         n.spi_tgl  = 1'b0;
         n.link_rst = 1'b1;
      end
   end

   // single state register
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         s          <= '0;
         s.pwr      <= ST_HW;
         s.div      <= DIV_START;
         s.txs      <= UT_IDLE;
         s.rxs      <= UT_IDLE;
         s.txd      <= 1'b1;
         s.hib_s    <= 2'h3;
         s.rxd_s    <= 2'h3;
         s.cts_s    <= 2'h3;
         s.link_rst <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign spi_bus.tx_byte = s.spi_tx;
   assign spi_bus.tx_tgl  = s.spi_tgl;
   assign spi_bus.link_rst = s.link_rst;
   // one attention pin serves both modes, always active high
   assign module_attention_line = s.attn;
   assign uart_txd    = s.txd;
   assign uart_rts_n  = !ready || s.rx_valid;
   assign tx_ready    = ready && !s.txw_full;
   assign rx_word     = s.rx_out;
   assign rx_valid    = s.rx_valid;
   assign link_ready  = ready;
   assign hibernating = (s.pwr == ST_HIB);
   // the 32 kHz oscillator keeps running in hibernate unless told off
   assign rtc_osc_en  = !(hibernating && rtc_stop_in_hib);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   a_hw_wake_len: assert property (s.pwr == ST_HW && s.hib_s[1]
      && hit(s.pcnt, P_HW_WAKE_CYC) |=> s.pwr == ST_INIT)
      else $error("hardware wake phase length wrong");
   a_init_len: assert property (s.pwr == ST_INIT && s.hib_s[1]
      && !hit(s.pcnt, P_INIT_CYC) |=> s.pwr == ST_INIT)
      else $error("init phase ended early");
   a_hib_entry: assert property (!s.hib_s[1] |=> hibernating)
      else $error("sleep request did not enter hibernate");
   a_hib_wake_len: assert property (s.pwr == ST_HWAKE && !s.recal
      && s.hib_s[1] && hit(s.pcnt, P_HIB_WAKE_CYC) |=> ready)
      else $error("hibernate wake time wrong");
   a_recal_extend: assert property (s.pwr == ST_HWAKE && s.recal
      && s.hib_s[1] && hit(s.pcnt, P_HIB_WAKE_CYC)
      |=> s.pwr == ST_HWAKE)
      else $error("recalibration time not added");
   a_attn_follow: assert property (ready && attn_req && s.hib_s[1]
      |=> module_attention_line)
      else $error("attention not raised");
   a_attn_quiet: assert property (!ready ##1 !ready
      |-> !module_attention_line)
      else $error("attention high while not ready");
   a_baud_restart: assert property (hibernating |=> s.div == DIV_START)
      else $error("baud divisor not restored");
   a_baud_floor: assert property (s.div >= DIV_MIN)
      else $error("baud divisor below floor");
   a_start_bit: assert property ($rose(s.txs == UT_START)
      |-> !uart_txd && $past(!s.cts_s[1]))
      else $error("start bit or flow control wrong");
   a_stop_bit: assert property (s.txs == UT_STOP |-> uart_txd)
      else $error("stop bit not high");
   a_word_pack: assert property (rx_valid && !$past(rx_valid)
      |-> s.rxi == 2'h0)
      else $error("word completed off byte boundary");

   c_ready: cover property (s.pwr == ST_INIT ##1 ready);
   c_recal_wake: cover property (s.pwr == ST_HWAKE && s.recal ##1 ready);
   c_uart_byte: cover property (s.txs == UT_STOP ##1 s.txs == UT_IDLE);
   c_word_in: cover property ($rose(rx_valid));
endmodule : nmhl_core
`default_nettype wire

// ==== core/nmhl_spi_link.sv ====
// Purpose: SPI mode 0 byte engine running on the host clock
// Assumes: host clock idles low and stops outside frames
// Notes:   bytes go MSB first; idle fill is sent when nothing is queued
`timescale 1ns/1ps
`default_nettype none
module nmhl_spi_link
   import nmhl_pkg::*;
(
   input  wire logic spi_clk,
   input  wire logic host_select_n,
   input  wire logic spi_mosi,
   output logic      spi_miso,
   output logic      spi_miso_oe,
   nmhl_spi_if.link  lnk
);
   typedef struct packed {
      logic [2:0] cnt;
      logic [6:0] shin;
      logic [7:0] cur;
      logic [1:0] tgl_s;
      logic       ack;
      logic [7:0] rxb;
      logic       rxt;
   } nmhl_spi_st_t;

   nmhl_spi_st_t s, n;
   logic         miso_r;

   // sample on rising edge, hand over a byte every eighth edge
   always_comb begin
      n       = s;
      n.cnt   = s.cnt + 3'h1;
      n.shin  = {s.shin[5:0], spi_mosi};
      n.tgl_s = {s.tgl_s[0], lnk.tx_tgl};
      if (s.cnt == BIT_LAST) begin
         n.rxb = {s.shin, spi_mosi};
         n.rxt = ~s.rxt;
         // next byte chosen now so its first bit is out before sampling
         if (s.tgl_s[1] != s.ack) begin
            n.cur = lnk.tx_byte;
            n.ack = s.tgl_s[1];
         end else begin
            n.cur = IDLE_FILL;
         end
      end
   end

   // select high restarts the bit count, so every frame starts at its first bit
   always_ff @(posedge spi_clk or posedge host_select_n
               or posedge lnk.link_rst) begin
      if (lnk.link_rst) begin
         s     <= '0;
         s.cur <= IDLE_FILL;
      end else if (host_select_n) begin
         s.cnt <= '0;
      end else begin
         s <= n;
      end
   end

   // launch on falling edge; the last fall of a byte shows the next MSB
   always_ff @(negedge spi_clk or posedge lnk.link_rst) begin
      if (lnk.link_rst) begin
         miso_r <= IDLE_FILL[7];
      end else begin
         miso_r <= s.cur[3'(BIT_LAST - s.cnt)];
      end
   end

   assign spi_miso     = miso_r;
   assign spi_miso_oe  = ~host_select_n;
   assign lnk.rx_byte  = s.rxb;
   assign lnk.rx_tgl   = s.rxt;
   assign lnk.tx_ack   = s.ack;

   a_byte_toggle: assert property (@(posedge spi_clk)
      disable iff (host_select_n || lnk.link_rst)
      s.cnt == BIT_LAST |=> s.rxt != $past(s.rxt))
      else $error("byte toggle missing after eighth edge");
   a_byte_value: assert property (@(posedge spi_clk)
      disable iff (host_select_n || lnk.link_rst)
      s.cnt == BIT_LAST |=> s.rxb == $past({s.shin, spi_mosi}))
      else $error("received byte differs from sampled bits");
endmodule : nmhl_spi_link
`default_nettype wire

// ==== include/nmhl_pkg.sv ====
// Purpose: shared constants and types of the module host link
// Assumes: core clock of 200 MHz, 8N1 serial framing
// Notes:   wake and baud counts are derived from times in their own units
// Summary of operation
// - host drives clock, select, MOSI; module drives MISO and attention
// - module raises attention line to ask the host to start a transfer
// - sleep request low puts module in hibernate; 32 kHz oscillator stays on unless rtc_stop_in_hib is high
// - leaving hibernate takes 50 ms before the host may use the module
// - large temperature drift adds up to 200 ms to hibernate wake-up
// - after reset: 25 ms hardware wake-up then 1.35 s initialisation
// - serial port starts at 115200 bps; host command raises it to 3 Mbps
// - 8 data bits, no parity, one stop, LSB first, CTS/RTS flow control
// - in serial mode the attention line is active high, edge or level
// - serial words are little-endian with fixed length, never detected
// - preferred wiring: four serial lines plus the attention line
package nmhl_pkg;
   localparam int CLK_MHZ     = 200;
   localparam int CLK_HZ      = CLK_MHZ * 1000000;
   localparam int HW_WAKE_US  = 25000;
   localparam int INIT_US     = 1350000;
   localparam int HIB_WAKE_US = 50000;
   localparam int RECAL_US    = 200000;
   localparam int HW_WAKE_CYC = HW_WAKE_US * CLK_MHZ;
   localparam int INIT_CYC    = INIT_US * CLK_MHZ;
   localparam int HIB_WAKE_CYC = HIB_WAKE_US * CLK_MHZ;
   localparam int RECAL_CYC   = RECAL_US * CLK_MHZ;
   localparam int CNT_W       = 29;
   localparam int BAUD_START  = 115200;
   localparam int BAUD_MAX    = 3000000;
   localparam logic [15:0] DIV_START = 16'(CLK_HZ / BAUD_START);
   localparam logic [15:0] DIV_MIN   = 16'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
   localparam logic [2:0]  BIT_LAST  = 3'h7;
   localparam logic [1:0]  BYTE_LAST = 2'h3;
   localparam logic [7:0]  IDLE_FILL = 8'h00;
   localparam logic        LINK_SPI  = 1'b0;
   localparam logic        LINK_UART = 1'b1;
   typedef enum logic [4:0] {
      ST_HW    = 5'h01,
      ST_INIT  = 5'h02,
      ST_READY = 5'h04,
      ST_HIB   = 5'h08,
      ST_HWAKE = 5'h10
   } nmhl_pwr_t;
   typedef enum logic [3:0] {
      UT_IDLE  = 4'h1,
      UT_START = 4'h2,
      UT_DATA  = 4'h4,
      UT_STOP  = 4'h8
   } nmhl_uart_t;
endpackage : nmhl_pkg

// ==== include/nmhl_spi_if.sv ====
// Purpose: byte exchange between the core and the SPI link domain
// Assumes: toggles cross by two flops; bytes stay put between toggles
// Notes:   link_rst is a core flop used as async clear on the link side
`timescale 1ns/1ps
`default_nettype none
interface nmhl_spi_if;
   logic [7:0] rx_byte;
   logic       rx_tgl;
   logic [7:0] tx_byte;
   logic       tx_tgl;
   logic       tx_ack;
   logic       link_rst;
   modport core (input rx_byte, rx_tgl, tx_ack,
                 output tx_byte, tx_tgl, link_rst);
   modport link (output rx_byte, rx_tgl, tx_ack,
                 input tx_byte, tx_tgl, link_rst);
endinterface : nmhl_spi_if
`default_nettype wire
